/* File: sfs_host_model.sv */
// Host model: the motion controller that drives the hardware enable pin.
// Assumes the bench raises or drops en_req; the pin follows LAG+1 cycles later.
`timescale 1ns/1ps
module sfs_host_model #(
    parameter int LAG = 3
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // Bench request and enable pin
    input  wire logic en_req,
    output logic      enable_pin
);
    logic [7:0] cnt_r;

    // A slow host is modelled by a larger LAG; the pin never glitches.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r      <= 8'h00;
            enable_pin <= 1'b0;
        end else if (en_req == enable_pin) begin
            cnt_r <= 8'h00;
        end else if (cnt_r == 8'(LAG)) begin
            enable_pin <= en_req;
            cnt_r      <= 8'h00;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
endmodule : sfs_host_model

/* File: sfs_pin_sync.sv */
// Three-stage synchroniser for asynchronous pin levels.
// Assumes the pins are slow levels; a change is accepted once stages two
// and three agree, so a single-cycle glitch after stage one is dropped.
`timescale 1ns/1ps
module sfs_pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst,
    // Pin side
    input  wire logic [W-1:0] pin_in,
    // Core side
    output logic      [W-1:0] level_q
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    always_comb begin
        for (int i = 0; i < W; i++) begin
            q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r  <= '0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r  <= q_nxt;
        end
    end

    assign level_q = q_r;

endmodule : sfs_pin_sync

/* File: sfs_pkg.sv */
// Package for the servo fault supervisor: register map, field positions,
// reset values and timing constants.
// Assumes a single 40 MHz core clock shared by every user of the package.
package sfs_pkg;

    // Register byte offsets on the Avalon-MM slave.
    localparam logic [5:0] REG_CTRL       = 6'h00;
    localparam logic [5:0] REG_STATUS     = 6'h04;
    localparam logic [5:0] REG_IRQ_STAT   = 6'h08;
    localparam logic [5:0] REG_IRQ_MASK   = 6'h0c;
    localparam logic [5:0] REG_STAT_BAND  = 6'h10;
    localparam logic [5:0] REG_DYN_RATIO  = 6'h14;
    localparam logic [5:0] REG_WARN_VEL   = 6'h18;
    localparam logic [5:0] REG_WARN_TIME  = 6'h1c;

    // Control register fields.
    localparam int CTRL_SW_EN     = 0;
    localparam int CTRL_MODE_LO   = 1;
    localparam int CTRL_BRAKE_FIT = 3;
    localparam int CTRL_FIELDBUS  = 4;
    localparam logic [4:0] CTRL_RST = 5'h00;

    // Operating modes held in the control register.
    localparam logic [1:0] MODE_VEL    = 2'h0;
    localparam logic [1:0] MODE_POS    = 2'h1;
    localparam logic [1:0] MODE_INTERP = 2'h2;

    // Interrupt status and mask bits.
    localparam int IRQ_SHORT   = 0;
    localparam int IRQ_OVOLT   = 1;
    localparam int IRQ_NONFTL  = 2;
    localparam int IRQ_POSWARN = 3;
    localparam int IRQ_VELWARN = 4;
    localparam int IRQ_OTHFTL  = 5;
    localparam int IRQ_W       = 6;

    // Dynamic ratio is unsigned with RATIO_FRAC fraction bits; RATIO_ONE is 100 percent.
    localparam int          RATIO_FRAC = 8;
    localparam logic [15:0] RATIO_ONE  = 16'h0100;
    localparam logic [31:0] BAND_RST   = 32'h0000_0000;
    localparam logic [31:0] WVEL_RST   = 32'h0000_0000;
    localparam logic [15:0] WTIME_RST  = 16'h0000;

    // Timing: millisecond tick and display blink half period.
    localparam int CLK_HZ     = 40_000_000;
    localparam int TICK_MS    = 1;
    localparam int MS_CYC     = CLK_HZ / 1000 * TICK_MS;
    localparam int BLINK_MS   = 250;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_RUN,
        ST_DECEL,
        ST_FAULT
    } sfs_state_e;

endpackage : sfs_pkg

/* File: sfs_supervisor.sv */
// Servo fault supervisor: fault classing, amplifier enable, latched fault
// codes, tracking warnings and an Avalon-MM register slave with interrupt.
// Assumes fault and enable pins are asynchronous; error and velocity inputs
// and the nonfatal/motor-stopped flags come from logic on core_clk.
//
// Contract
// R1 - Fatal fault stops amplifier switching at once, no controlled deceleration.
// R2 - Nonfatal fault: emergency-rate servo stop first, then amplifier disabled.
// R3 - Every fault ends with amplifier power removed; warnings never halt operation.
// R4 - With fieldbus or point motion in use, fault reaction engages fitted brake; code engages it only when the fieldbus bit is set.
// R5 - Warnings are reported but the drive keeps controlling, amplifier stays on.
// R6 - Short-circuit detection disables inverter and raises the short fault code.
// R7 - Short fault stays latched after current ceases, cleared only on re-enable.
// R8 - Bus over-voltage disables inverter, raises its code, latched until re-enable.
// R9 - Interpolation mode holds a programmable static position error band.
// R10 - A dynamic error ratio scales expected error; values below 100% allowed.
// R11 - Position tracking warning shown when error exceeds the allowed error.
// R12 - Velocity tracking monitoring also runs in position mode.
// R13 - Velocity warning flashes after error exceeds threshold for warning time.
// R14 - Operator asserts the hardware enable first, then the software enable.
// R15 - Tuning generator uses 5 revolutions, 10% rated speed, 10 s period.
// R16 - Operator disables the drive through enable input before mode change.
// R17 - Allowed error is static band plus ratio times expected error.
`timescale 1ns/1ps
module sfs_supervisor
    import sfs_pkg::*;
#(
    parameter int POS_W     = 32,
    parameter int VEL_W     = 32,
    parameter int MS_CYCLES = MS_CYC
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // Avalon-MM slave
    input  wire logic [5:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    output logic                   irq,
    // Pins and fault sources
    input  wire logic              enable_pin,
    input  wire logic              short_det_pin,
    input  wire logic              bus_ov_pin,
    input  wire logic              other_fatal_in,
    input  wire logic              nonfatal_in,
    input  wire logic              motor_stopped,
    // Tracking inputs
    input  wire logic [POS_W-1:0]  pos_error,
    input  wire logic [POS_W-1:0]  pos_expected,
    input  wire logic [VEL_W-1:0]  vel_cmd,
    input  wire logic [VEL_W-1:0]  vel_act,
    // Drive outputs
    output logic                   amp_en,
    output logic                   emerg_decel,
    output logic                   brake_engage,
    output logic                   amp_short_fault_code,
    output logic                   bus_overvolt_fault_code,
    output logic                   seg_pos_warn,
    output logic                   seg_vel_flash
);

    localparam int AW = POS_W + 16 - RATIO_FRAC + 1;

    function automatic logic [POS_W-1:0] mag_p(input logic [POS_W-1:0] v);
        mag_p = v[POS_W-1] ? POS_W'(-v) : v;
    endfunction : mag_p

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.
    logic en_q;
    logic short_q;
    logic ovolt_q;

    sfs_pin_sync #(.W(3)) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pin_in   ({enable_pin, short_det_pin, bus_ov_pin}),
        .level_q  ({en_q, short_q, ovolt_q})
    );

    ////////////////////////////////////////////////////////////////////////////
    // Registers and bus slave.
    logic [4:0]        ctrl_r,  ctrl_nxt;
    logic [IRQ_W-1:0]  ist_r,   ist_nxt;
    logic [IRQ_W-1:0]  imask_r, imask_nxt;
    logic [31:0]       band_r,  band_nxt;
    logic [15:0]       ratio_r, ratio_nxt;
    logic [31:0]       wvel_r,  wvel_nxt;
    logic [15:0]       wtime_r, wtime_nxt;
    logic              wait_r,  wait_nxt;
    logic [31:0]       rdata_r, rdata_nxt;
    logic              irq_r,   irq_nxt;
    logic [IRQ_W-1:0]  ev;
    logic              wr_go;
    logic [1:0]        mode;
    sfs_state_e        st_r, st_nxt;
    logic              short_r, ovolt_r, posw_r, velw_r;

    assign wr_go = avs_write && !wait_r;
    assign mode  = ctrl_r[CTRL_MODE_LO +: 2];

    always_comb begin
        ctrl_nxt  = ctrl_r;
        imask_nxt = imask_r;
        band_nxt  = band_r;
        ratio_nxt = ratio_r;
        wvel_nxt  = wvel_r;
        wtime_nxt = wtime_r;
        // Acknowledge every request one cycle after it is seen.
        wait_nxt  = !((avs_read || avs_write) && wait_r);
        rdata_nxt = rdata_r;
        // Hardware set wins over a write-one-to-clear in the same cycle.
        ist_nxt   = (ist_r & ~(wr_go && avs_address == REG_IRQ_STAT
                               ? avs_writedata[IRQ_W-1:0] : '0)) | ev;
        if (wr_go) begin
            case (avs_address)
                REG_CTRL:      ctrl_nxt  = avs_writedata[4:0];
                REG_IRQ_MASK:  imask_nxt = avs_writedata[IRQ_W-1:0];
                REG_STAT_BAND: band_nxt  = avs_writedata;          // R9
                REG_DYN_RATIO: ratio_nxt = avs_writedata[15:0];    // R10
                REG_WARN_VEL:  wvel_nxt  = avs_writedata;
                REG_WARN_TIME: wtime_nxt = avs_writedata[15:0];
                default:       ;
            endcase
        end
        if ((avs_read || avs_write) && wait_r) begin
            case (avs_address)
                REG_CTRL:      rdata_nxt = {27'h0, ctrl_r};
                REG_STATUS:    rdata_nxt = {24'h0, en_q, amp_en, velw_r, posw_r,
                                            ovolt_r, short_r, st_r};
                REG_IRQ_STAT:  rdata_nxt = {26'h0, ist_r};
                REG_IRQ_MASK:  rdata_nxt = {26'h0, imask_r};
                REG_STAT_BAND: rdata_nxt = band_r;
                REG_DYN_RATIO: rdata_nxt = {16'h0, ratio_r};
                REG_WARN_VEL:  rdata_nxt = wvel_r;
                REG_WARN_TIME: rdata_nxt = {16'h0, wtime_r};
                default:       rdata_nxt = 32'h0;
            endcase
        end
        irq_nxt = |(ist_nxt & imask_r);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_r  <= CTRL_RST;
            ist_r   <= '0;
            imask_r <= '0;
            band_r  <= BAND_RST;
            ratio_r <= RATIO_ONE;
            wvel_r  <= WVEL_RST;
            wtime_r <= WTIME_RST;
            wait_r  <= 1'b1;
            rdata_r <= 32'h0;
            irq_r   <= 1'b0;
        end else begin
            ctrl_r  <= ctrl_nxt;
            ist_r   <= ist_nxt;
            imask_r <= imask_nxt;
            band_r  <= band_nxt;
            ratio_r <= ratio_nxt;
            wvel_r  <= wvel_nxt;
            wtime_r <= wtime_nxt;
            wait_r  <= wait_nxt;
            rdata_r <= rdata_nxt;
            irq_r   <= irq_nxt;
        end
    end

    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;
    assign irq             = irq_r;

    ////////////////////////////////////////////////////////////////////////////
    // Fault state machine and latched fault codes.
    logic en_req, en_d_r, en_rise, fatal;
    logic short_nxt, ovolt_nxt, amp_r, amp_nxt, decel_r, decel_nxt;
    logic brake_r, brake_nxt;

    assign en_req  = en_q && ctrl_r[CTRL_SW_EN];
    assign en_rise = en_req && !en_d_r;
    // Fatal sources act on the live level so switching stops at once.
    assign fatal   = short_q || ovolt_q || other_fatal_in;

    always_comb begin
        st_nxt    = st_r;
        // A live fault level sets again, so re-enabling into a fault relatches.
        short_nxt = short_q || (short_r && !en_rise);     // R6 R7
        ovolt_nxt = ovolt_q || (ovolt_r && !en_rise);     // R8
        case (st_r)
            ST_OFF:   if (en_rise) st_nxt = ST_RUN;
            ST_RUN: begin
                if (fatal)            st_nxt = ST_FAULT;  // R1
                else if (nonfatal_in) st_nxt = ST_DECEL;  // R2
                else if (!en_req)     st_nxt = ST_OFF;
            end
            ST_DECEL: begin
                if (fatal || motor_stopped) st_nxt = ST_FAULT;  // R2
            end
            ST_FAULT: if (!en_req) st_nxt = ST_OFF;
            default:  st_nxt = ST_OFF;
        endcase
        // Warnings never enter this decision, so they cannot halt the drive.
        amp_nxt   = (st_nxt == ST_RUN) || (st_nxt == ST_DECEL);  // R3 R5
        decel_nxt = (st_nxt == ST_DECEL);
        brake_nxt = (st_nxt == ST_FAULT) && ctrl_r[CTRL_BRAKE_FIT]
                    && ctrl_r[CTRL_FIELDBUS];                    // R4
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_r    <= ST_OFF;
            en_d_r  <= 1'b0;
            short_r <= 1'b0;
            ovolt_r <= 1'b0;
            amp_r   <= 1'b0;
            decel_r <= 1'b0;
            brake_r <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            en_d_r  <= en_req;
            short_r <= short_nxt;
            ovolt_r <= ovolt_nxt;
            amp_r   <= amp_nxt;
            decel_r <= decel_nxt;
            brake_r <= brake_nxt;
        end
    end

    assign amp_en                  = amp_r;
    assign emerg_decel             = decel_r;
    assign brake_engage            = brake_r;
    assign amp_short_fault_code    = short_r;
    assign bus_overvolt_fault_code = ovolt_r;

    ////////////////////////////////////////////////////////////////////////////
    // Tracking monitors with a millisecond enable and display blink.
    logic [31:0]      msc_r, msc_nxt;
    logic             tick_r, tick_nxt;
    logic [15:0]      blc_r, blc_nxt, vcnt_r, vcnt_nxt;
    logic             blink_r, blink_nxt, vel_over, posw_nxt, velw_nxt;
    logic             flash_r, flash_nxt;
    logic [AW-1:0]    allowed;
    logic [VEL_W:0]   verr;
    logic [VEL_W:0]   verr_mag;

    always_comb begin
        allowed  = AW'(band_r[POS_W-1:0]) + AW'(((POS_W+16)'(ratio_r)
                 * (POS_W+16)'(mag_p(pos_expected))) >> RATIO_FRAC);  // R17
        verr     = {vel_cmd[VEL_W-1], vel_cmd} - {vel_act[VEL_W-1], vel_act};
        verr_mag = verr[VEL_W] ? (VEL_W+1)'(-verr) : verr;
        vel_over = (mode == MODE_VEL || mode == MODE_POS)              // R12
                   && (verr_mag > {1'b0, wvel_r[VEL_W-1:0]});
        tick_nxt = (msc_r == 32'(MS_CYCLES - 1));
        msc_nxt  = tick_nxt ? 32'h0 : msc_r + 32'h1;
        blc_nxt  = blc_r;
        blink_nxt = blink_r;
        if (tick_r) begin
            blc_nxt = (blc_r == 16'(BLINK_MS - 1)) ? 16'h0 : blc_r + 16'h1;
            if (blc_r == 16'(BLINK_MS - 1)) blink_nxt = !blink_r;
        end
        vcnt_nxt = !vel_over ? 16'h0
                 : (tick_r && vcnt_r != 16'hffff) ? vcnt_r + 16'h1 : vcnt_r;
        velw_nxt  = vel_over && (vcnt_r >= wtime_r);                   // R13
        flash_nxt = velw_r && blink_r;
        posw_nxt  = (mode == MODE_INTERP)
                    && (AW'(mag_p(pos_error)) > allowed);              // R11
        ev = '0;
        ev[IRQ_SHORT]   = short_q && !short_r;
        ev[IRQ_OVOLT]   = ovolt_q && !ovolt_r;
        ev[IRQ_NONFTL]  = (st_r == ST_RUN) && (st_nxt == ST_DECEL);
        ev[IRQ_POSWARN] = posw_nxt && !posw_r;
        ev[IRQ_VELWARN] = velw_nxt && !velw_r;
        ev[IRQ_OTHFTL]  = other_fatal_in && (st_r != ST_FAULT) && (st_r != ST_OFF);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            msc_r   <= 32'h0;
            tick_r  <= 1'b0;
            blc_r   <= 16'h0;
            blink_r <= 1'b0;
            vcnt_r  <= 16'h0;
            velw_r  <= 1'b0;
            posw_r  <= 1'b0;
            flash_r <= 1'b0;
        end else begin
            msc_r   <= msc_nxt;
            tick_r  <= tick_nxt;
            blc_r   <= blc_nxt;
            blink_r <= blink_nxt;
            vcnt_r  <= vcnt_nxt;
            velw_r  <= velw_nxt;
            posw_r  <= posw_nxt;
            flash_r <= flash_nxt;
        end
    end

    assign seg_pos_warn  = posw_r;
    assign seg_vel_flash = flash_r;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence run_nonfatal_s;
        st_r == ST_RUN && !fatal && nonfatal_in;
    endsequence

    sequence stopped_in_decel_s;
        st_r == ST_DECEL && !fatal && motor_stopped;
    endsequence

    fatal_amp_off_a: assert property (                                // R1
        (st_r == ST_RUN || st_r == ST_DECEL) && fatal |=> !amp_en && !emerg_decel)
        else $error("fatal fault left the amplifier enabled");
    decel_before_off_a: assert property (                             // R2
        run_nonfatal_s |=> amp_en && emerg_decel)
        else $error("nonfatal fault did not start an emergency stop");
    decel_end_off_a: assert property (                                // R2
        stopped_in_decel_s |=> !amp_en ##0 !emerg_decel)
        else $error("amplifier still on after emergency stop");
    fault_no_power_a: assert property (st_r == ST_FAULT |-> !amp_en)  // R3
        else $error("amplifier powered in fault state");
    fault_brake_a: assert property (                                  // R4
        st_r == ST_FAULT && en_req && $stable(ctrl_r) && ctrl_r[CTRL_BRAKE_FIT]
        && ctrl_r[CTRL_FIELDBUS] |=> brake_engage)
        else $error("brake not engaged on fault");
    warn_keeps_run_a: assert property (                               // R5
        st_r == ST_RUN && !fatal && !nonfatal_in && en_req |=> amp_en)
        else $error("drive stopped without a fault");
    short_latch_a: assert property (                                  // R6
        short_q |=> amp_short_fault_code)
        else $error("short fault code not raised");
    short_hold_a: assert property (                                   // R7
        amp_short_fault_code && !en_rise |=> amp_short_fault_code)
        else $error("short fault code lost before re-enable");
    ovolt_hold_a: assert property (                                   // R8
        (ovolt_q || (bus_overvolt_fault_code && !en_rise)) |=> bus_overvolt_fault_code)
        else $error("over-voltage code not latched");
    pos_warn_a: assert property (                                     // R11
        mode == MODE_INTERP && $stable(mode)
        && AW'(mag_p(pos_error)) > allowed |=> seg_pos_warn)
        else $error("position tracking warning missing");
    vel_time_a: assert property (velw_r |-> $past(vcnt_r) >= $past(wtime_r))  // R13
        else $error("velocity warning before warning time");

endmodule : sfs_supervisor

/* File: tb.sv */
// Self-checking bench for the servo fault supervisor.
// Assumes a 40 MHz clock and a millisecond tick shortened to MSC cycles.
`timescale 1ns/1ps
module tb;
    import sfs_pkg::*;
    localparam int MSC = 10;
    logic        core_clk = 1'b0, rst = 1'b1, host_en = 1'b0, enable_pin;
    logic [5:0]  avs_address = 6'h00;
    logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, irq;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic        short_det_pin = 1'b0, bus_ov_pin = 1'b0, other_fatal_in = 1'b0;
    logic        nonfatal_in = 1'b0, motor_stopped = 1'b0;
    logic [31:0] pos_error = 32'h0, pos_expected = 32'h0, vel_cmd = 32'h0, vel_act = 32'h0;
    logic        amp_en, emerg_decel, brake_engage, amp_short_fault_code;
    logic        bus_overvolt_fault_code, seg_pos_warn, seg_vel_flash;
    int          errors = 0, tests_run = 0, cyc = 0;

    sfs_supervisor #(.MS_CYCLES(MSC)) i_sfs_supervisor (
        .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .enable_pin(enable_pin),
        .short_det_pin(short_det_pin), .bus_ov_pin(bus_ov_pin),
        .other_fatal_in(other_fatal_in), .nonfatal_in(nonfatal_in),
        .motor_stopped(motor_stopped), .pos_error(pos_error), .pos_expected(pos_expected),
        .vel_cmd(vel_cmd), .vel_act(vel_act), .amp_en(amp_en), .emerg_decel(emerg_decel),
        .brake_engage(brake_engage), .amp_short_fault_code(amp_short_fault_code),
        .bus_overvolt_fault_code(bus_overvolt_fault_code), .seg_pos_warn(seg_pos_warn),
        .seg_vel_flash(seg_vel_flash));
    sfs_host_model #(.LAG(3)) i_sfs_host_model (
        .core_clk(core_clk), .rst(rst), .en_req(host_en), .enable_pin(enable_pin));

    always #12.5 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up

    // A hung run still reaches the single closing report.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            errors++;
            wrap_up();
        end
    end

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // One Avalon-MM cycle; the request stands until waitrequest is sampled low.
    task automatic bus(logic wr, logic [5:0] a, logic [31:0] d, output logic [31:0] q);
        int n = 0;
        @(posedge core_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        chk("bus answer", 0, n >= 50);
    endtask : bus

    task automatic wr(logic [5:0] a, logic [31:0] d);
        bus(1'b1, a, d, rd);
    endtask : wr

    task automatic cyc_n(int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc_n

    // Pin drops first, mode is set while disabled, then pin and software enable.
    task automatic power_up(logic [4:0] ctrl);
        host_en <= 1'b0;
        cyc_n(12);
        wr(REG_CTRL, {27'h0, ctrl});
        host_en <= 1'b1;
        cyc_n(12);
        wr(REG_CTRL, {27'h0, ctrl | 5'h01});
        cyc_n(3);
        chk("amp_en on enable", 1, amp_en);
    endtask : power_up

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [5:0]  a[8] = '{REG_CTRL, REG_IRQ_STAT, REG_IRQ_MASK, REG_STAT_BAND,
                              REG_DYN_RATIO, REG_WARN_VEL, REG_WARN_TIME, 6'h3c};
        logic [31:0] e[8] = '{0, 0, 0, BAND_RST, RATIO_ONE, WVEL_RST, WTIME_RST, 0};
        chk("waitrequest idle", 1, avs_waitrequest);
        chk("amp_en reset", 0, amp_en);
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, a[i], 0, rd);
            chk("register reset", e[i], rd);
        end
    endtask : t_reset

    task automatic t_fatal(int src);
        int n = 0;
        logic dec = 1'b0;
        power_up(5'h18);
        wr(REG_IRQ_MASK, 32'h3f);
        short_det_pin  <= (src == 0);
        bus_ov_pin     <= (src == 1);
        other_fatal_in <= (src == 2);
        while (amp_en !== 1'b0 && n < 12) begin
            @(posedge core_clk);
            dec |= (emerg_decel !== 1'b0);
            n++;
        end
        chk("no decel on fatal", 0, dec);
        chk("amp off on fatal", 0, amp_en);
        chk("short code", src == 0, amp_short_fault_code);
        chk("ovolt code", src == 1, bus_overvolt_fault_code);
        chk("brake on fault", 1, brake_engage);
        short_det_pin  <= 1'b0;
        bus_ov_pin     <= 1'b0;
        other_fatal_in <= 1'b0;
        cyc_n(10);
        chk("short code held", src == 0, amp_short_fault_code);
        chk("ovolt code held", src == 1, bus_overvolt_fault_code);
        bus(1'b0, REG_STATUS, 0, rd);
        chk("fault state", 3, rd[1:0]);
        bus(1'b0, REG_IRQ_STAT, 0, rd);
        chk("irq status", 1, rd[(src == 2) ? IRQ_OTHFTL : src]);
        chk("irq line", 1, irq);
        wr(REG_IRQ_STAT, 32'h3f);
        cyc_n(2);
        chk("irq cleared", 0, irq);
        power_up(5'h00);
        chk("codes cleared", 0, {amp_short_fault_code, bus_overvolt_fault_code});
    endtask : t_fatal

    task automatic t_nonfatal;
        power_up(5'h00);
        nonfatal_in <= 1'b1;
        cyc_n(3);
        chk("decel started", 1, emerg_decel);
        chk("amp held in decel", 1, amp_en);
        nonfatal_in <= 1'b0;
        cyc_n(5);
        chk("amp held until stop", 1, amp_en);
        motor_stopped <= 1'b1;
        cyc_n(3);
        chk("amp off after stop", 0, amp_en);
        chk("decel ended", 0, emerg_decel);
        motor_stopped <= 1'b0;
        bus(1'b0, REG_IRQ_STAT, 0, rd);
        chk("nonfatal irq bit", 1, rd[IRQ_NONFTL]);
        wr(REG_IRQ_STAT, 32'h3f);
    endtask : t_nonfatal

    // Band 10 plus half of 20 allows an error of exactly 20 increments.
    task automatic t_pos_warn;
        logic [31:0] pe[5] = '{20, 21, -21, -20, 31};
        logic [31:0] px[5] = '{20, 20, 20, -20, 40};
        logic        ex[5] = '{0, 1, 1, 0, 1};
        power_up(5'h04);
        wr(REG_STAT_BAND, 10);
        wr(REG_DYN_RATIO, 32'h80);
        for (int i = 0; i < 5; i++) begin
            pos_error    <= pe[i];
            pos_expected <= px[i];
            cyc_n(4);
            chk("position warning", ex[i], seg_pos_warn);
            chk("amp on with warning", 1, amp_en);
        end
        pos_error <= 32'h0;
        wr(REG_IRQ_STAT, 32'h3f);
    endtask : t_pos_warn

    task automatic t_vel_warn;
        int n = 0;
        power_up(5'h02);
        wr(REG_WARN_VEL, 5);
        wr(REG_WARN_TIME, 2);
        // Command a tenth of a rated speed of 1000, as a position tuning run would.
        vel_cmd <= 1000 / 10;
        vel_act <= 94;
        cyc_n(2);
        bus(1'b0, REG_STATUS, 0, rd);
        chk("vel warn early", 0, rd[5]);
        cyc_n(4 * MSC);
        bus(1'b0, REG_STATUS, 0, rd);
        chk("vel warn in pos mode", 1, rd[5]);
        while (seg_vel_flash !== 1'b1 && n < 600 * MSC) begin
            @(posedge core_clk);
            n++;
        end
        chk("vel flash", 1, seg_vel_flash);
        chk("amp on with vel warn", 1, amp_en);
        vel_act <= 95;
        cyc_n(5);
        bus(1'b0, REG_STATUS, 0, rd);
        chk("vel warn at threshold", 0, rd[5]);
    endtask : t_vel_warn

    initial begin
        cyc_n(4);
        rst <= 1'b0;
        t_reset();
        for (int s = 0; s < 3; s++) t_fatal(s);
        t_nonfatal();
        t_pos_warn();
        t_vel_warn();
        wrap_up();
    end
endmodule : tb
